// *** fmsp_pkg.sv ***
/*
 Shared constants and types of the four-mode serial port: register map,
 field positions, reset values, timing counts, states and the control layout.
 Assumes a 32-bit APB with byte addresses and one aligned word per register.
*/
package fmsp_pkg;
   // ************************************************
   // register map and reset values
   // ************************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_CTRL = 12'h098;
   localparam logic [11:0] OFS_BUF = 12'h09c;
   localparam logic [11:0] OFS_PWR = 12'h0a0;
   localparam logic [11:0] OFS_BAUD = 12'h0a4;
   localparam logic [11:0] OFS_RLD = 12'h0a8;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PWR_RST = 8'h00;
   localparam logic [2:0] BSEL_RST = 3'h0;
   localparam logic [15:0] RLD_RST = 16'h0000;

   // ************************************************
   // field positions
   // ************************************************
   localparam int PWR_FES_BIT = 6;
   localparam int PWR_DBL_BIT = 7;
   localparam int BSEL_TX_BIT = 0;
   localparam int BSEL_RX_BIT = 1;
   localparam int BSEL_EXT_BIT = 2;

   // ************************************************
   // timing counts
   // ************************************************
   localparam logic [2:0] SYNC_PH_LAST = 3'h5; // six clocks per shift bit
   localparam logic [2:0] SYNC_PH_RISE = 3'h3;
   localparam logic [3:0] SYNC_BITS = 4'h7;
   localparam logic [3:0] OVS_LAST = 4'hf; // sixteen ticks per bit
   localparam logic [3:0] SMP_1 = 4'h6;
   localparam logic [3:0] SMP_2 = 4'h7;
   localparam logic [3:0] SMP_3 = 4'h8;
   localparam logic [3:0] LAST_M8 = 4'h9; // stop index, ten-bit frame
   localparam logic [3:0] LAST_M9 = 4'ha; // stop index, eleven-bit frame
   localparam logic [15:0] T2_TOP = 16'hffff;

   // ************************************************
   // types
   // ************************************************
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_UART8 = 2'b01,
      MODE_UART9F = 2'b10,
      MODE_UART9V = 2'b11
   } fmsp_mode_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_ASYNC = 2'b01,
      TX_SYNC = 2'b11
   } fmsp_tx_st_t;

   typedef enum logic {
      RX_IDLE = 1'b0,
      RX_ASYNC = 1'b1
   } fmsp_rx_st_t;

   typedef struct packed {
      logic mode_select_upper;
      logic mode_select_lower;
      logic multiproc_filter_enable;
      logic rx_enable;
      logic tx_ninth_bit;
      logic rx_ninth_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } fmsp_ctrl_t;
endpackage : fmsp_pkg

// *** fmsp_serial_port.sv ***
/*
 Four-mode serial port: shift-register mode, 8-bit and 9-bit UART modes,
 internal baud timer with reload, APB register slave.
 Assumes an APB master on sys_clk_i, a timer-1 overflow pulse on the same
 clock, and an outside wire resolving rxd from rxd_o and rxd_oe_o.
*/
// Functional notes
// - shift mode moves eight bits, LSB first
// - shift mode bit rate is clock/6
// - shift clock on transmit line both directions
// - 8-bit frame: start, eight data, stop
// - 8-bit mode stores stop bit in ninth
// - external timer clock: rate is overflow/16
// - internal timer: fosc/(16*(65536-reload))
// - 9-bit frame adds software ninth bit
// - mode 2 keeps ninth bit, ignores stop
// - mode 2 rate clock/16 or clock/32
// - mode 3 equals mode 2, variable rate
// - bit 7 is mode or frame error
// - frame error sticky until software write
// - mode bits decode into four modes
// - filter drops 9-bit frames with zero ninth
// - filter drops 8-bit frames with bad stop
// - receive only while receive enable set
// - transmit done set as the stop bit starts, shift mode after bit eight
// - receive done set at the stop bit vote, shift mode after bit eight
// - frame error shown only when selected
// - sixteen ticks per bit, majority of three
// - load only if done clear and filter passes
// - per direction timer 1 or timer 2
`timescale 1ns/1ps
module fmsp_serial_port
   import fmsp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // baud sources
   input wire logic timer1_ovf_i,
   input wire logic timer_ext_count_pin_i,
   // serial pins
   input wire logic rxd_i,
   output logic rxd_o,
   output logic rxd_oe_o,
   output logic txd_o
);
   // ************************************************
   // helpers
   // ************************************************
   function automatic logic fmsp_maj3(input logic a, input logic b, input logic c);
      fmsp_maj3 = (a & b) | (a & c) | (b & c);
   endfunction : fmsp_maj3

   function automatic logic [3:0] fmsp_last_bit(input logic nine);
      fmsp_last_bit = nine ? LAST_M9 : LAST_M8;
   endfunction : fmsp_last_bit

   // ************************************************
   // state
   // ************************************************
   fmsp_ctrl_t ctl_q;
   logic fe_q;
   logic [7:0] buf_q;
   logic [7:0] pwr_q;
   logic [2:0] bsel_q;
   logic [15:0] rld_q;
   logic rdy_q;
   logic err_q;
   logic [31:0] rdat_q;
   logic [15:0] t2_q;
   logic t2_ovf_q;
   logic div_q;
   logic ext_m_q;
   logic ext_s_q;
   logic ext_p_q;
   logic rxd_m_q;
   logic rxd_s_q;
   logic rxd_p_q;
   fmsp_tx_st_t tx_st_q;
   logic [10:0] tsh_q;
   logic [3:0] tbit_q;
   logic [3:0] tos_q;
   logic [2:0] ph_q;
   logic sdir_q;
   fmsp_rx_st_t rx_st_q;
   logic [3:0] ros_q;
   logic [3:0] rbit_q;
   logic [9:0] rsh_q;
   logic [1:0] vote_q;
   logic txd_q;
   logic rxd_o_q;
   logic rxd_oe_q;

   // ************************************************
   // apb decode
   // ************************************************
   // one wait state; writes land only at the completing edge
   wire acc = psel_i & penable_i;
   wire setup_done = acc & ~rdy_q;
   wire hit_ctl = paddr_i == OFS_CTRL;
   wire hit_buf = paddr_i == OFS_BUF;
   wire hit_pwr = paddr_i == OFS_PWR;
   wire hit_bsel = paddr_i == OFS_BAUD;
   wire hit_rld = paddr_i == OFS_RLD;
   wire mapped = hit_ctl | hit_buf | hit_pwr | hit_bsel | hit_rld;
   wire wr_cmp = acc & rdy_q & pwrite_i;
   wire wr_lo = wr_cmp & pstrb_i[0];
   wire wr_ctl = wr_lo & hit_ctl;
   wire wr_buf = wr_lo & hit_buf;
   wire wr_pwr = wr_lo & hit_pwr;
   wire wr_bsel = wr_lo & hit_bsel;
   wire wr_rld_lo = wr_lo & hit_rld;
   wire wr_rld_hi = wr_cmp & pstrb_i[1] & hit_rld;
   wire fes = pwr_q[PWR_FES_BIT];
   wire dbl = pwr_q[PWR_DBL_BIT];
   // bit 7 shares mode and error roles
   wire [7:0] ctl_view = {fes ? fe_q : ctl_q.mode_select_upper, ctl_q[6:0]};
   wire [31:0] rd_mux = hit_ctl ? {24'h0, ctl_view} :
                        hit_buf ? {24'h0, buf_q} :
                        hit_pwr ? {24'h0, pwr_q} :
                        hit_bsel ? {29'h0, bsel_q} :
                        hit_rld ? {16'h0, rld_q} : 32'h0;

   // ************************************************
   // mode and baud ticks
   // ************************************************
   wire [1:0] mode_bits = {ctl_q.mode_select_upper, ctl_q.mode_select_lower};
   wire fmsp_mode_t mode = fmsp_mode_t'(mode_bits);
   wire m9 = mode_bits[1];
   wire [3:0] last = fmsp_last_bit(m9);
   // mode 2 tick every clock or every other clock
   wire m2_tk = dbl | div_q;
   wire tx_tk = (mode == MODE_UART9F) ? m2_tk :
                bsel_q[BSEL_TX_BIT] ? t2_ovf_q : timer1_ovf_i;
   wire rx_tk = (mode == MODE_UART9F) ? m2_tk :
                bsel_q[BSEL_RX_BIT] ? t2_ovf_q : timer1_ovf_i;
   // timer 2 counts clocks or falling pin edges
   wire t2_inc = bsel_q[BSEL_EXT_BIT] ? (ext_p_q & ~ext_s_q) : 1'b1;
   wire t2_top = t2_inc & (t2_q == T2_TOP);

   // ************************************************
   // transmit and shift engine decode
   // ************************************************
   // writes during a transfer are dropped, never queued
   wire tx_go = wr_buf & (tx_st_q == TX_IDLE);
   wire srx_go = (mode == MODE_SHIFT) & ctl_q.rx_enable & ~ctl_q.rx_done_flag &
                 (tx_st_q == TX_IDLE) & ~tx_go;
   wire a_bit_end = (tx_st_q == TX_ASYNC) & tx_tk & (tos_q == OVS_LAST);
   wire s_bit_end = (tx_st_q == TX_SYNC) & (ph_q == SYNC_PH_LAST);
   wire s_last = s_bit_end & (tbit_q == SYNC_BITS);
   wire a_stop_in = a_bit_end & (tbit_q == last - 4'h1);
   wire tx_evt = a_stop_in | (s_last & ~sdir_q);
   wire s_rx_load = s_last & sdir_q;
   wire s_smp = (tx_st_q == TX_SYNC) & (ph_q == SYNC_PH_RISE);

   // ************************************************
   // receive decode
   // ************************************************
   wire rx_fall = rxd_p_q & ~rxd_s_q;
   wire rx_start = (rx_st_q == RX_IDLE) & (mode != MODE_SHIFT) &
                   ctl_q.rx_enable & rx_fall;
   wire rx_vote = (rx_st_q == RX_ASYNC) & rx_tk & (ros_q == SMP_3);
   wire maj = fmsp_maj3(vote_q[1], vote_q[0], rxd_s_q);
   wire rx_false = rx_vote & (rbit_q == 4'h0) & maj;
   wire rx_final = rx_vote & (rbit_q == last);
   wire [9:0] rx_frame = {maj, rsh_q[9:1]};
   wire [7:0] rx_byte = m9 ? rx_frame[7:0] : rx_frame[8:1];
   wire rx_ninth = m9 ? rx_frame[8] : maj;
   // a full holding register or a failed filter loses the frame
   wire a_rx_load = rx_final & ~ctl_q.rx_done_flag &
                    (~ctl_q.multiproc_filter_enable | rx_ninth);
   wire fe_evt = rx_final & ~maj;
   wire rx_load = a_rx_load | s_rx_load;

   // ************************************************
   // apb answer
   // ************************************************
   // read data captured in the first access cycle, shown with pready
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         rdat_q <= 32'h0;
      end else begin
         rdy_q <= setup_done;
         err_q <= setup_done & ~mapped;
         rdat_q <= (setup_done & ~pwrite_i) ? rd_mux : 32'h0;
      end
   end

   // ************************************************
   // software registers
   // ************************************************
   // hardware set wins over a same-cycle software clear
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_q <= CTRL_RST;
         fe_q <= 1'b0;
         pwr_q <= PWR_RST;
         bsel_q <= BSEL_RST;
         rld_q <= RLD_RST;
         buf_q <= 8'h00;
      end else begin
         if (wr_ctl) begin
            ctl_q[6:2] <= pwdata_i[6:2];
            if (!fes) begin
               ctl_q.mode_select_upper <= pwdata_i[7];
            end
         end
         ctl_q.tx_done_flag <= tx_evt | (wr_ctl ? pwdata_i[1] : ctl_q.tx_done_flag);
         ctl_q.rx_done_flag <= rx_load | (wr_ctl ? pwdata_i[0] : ctl_q.rx_done_flag);
         if (a_rx_load) begin
            ctl_q.rx_ninth_bit <= rx_ninth;
         end
         fe_q <= fe_evt | ((wr_ctl & fes) ? pwdata_i[7] : fe_q);
         if (wr_pwr) begin
            pwr_q <= pwdata_i[7:0];
         end
         if (wr_bsel) begin
            bsel_q <= pwdata_i[2:0];
         end
         if (wr_rld_lo) begin
            rld_q[7:0] <= pwdata_i[7:0];
         end
         if (wr_rld_hi) begin
            rld_q[15:8] <= pwdata_i[15:8];
         end
         if (a_rx_load) begin
            buf_q <= rx_byte;
         end else if (s_rx_load) begin
            buf_q <= tsh_q[7:0];
         end
      end
   end

   // ************************************************
   // baud timer and synchronisers
   // ************************************************
   // reload on overflow gives 65536-reload clocks per tick
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         t2_q <= 16'h0000;
         t2_ovf_q <= 1'b0;
         div_q <= 1'b0;
         ext_m_q <= 1'b0;
         ext_s_q <= 1'b0;
         ext_p_q <= 1'b0;
         rxd_m_q <= 1'b1;
         rxd_s_q <= 1'b1;
         rxd_p_q <= 1'b1;
      end else begin
         t2_q <= t2_top ? rld_q : t2_q + {15'h0, t2_inc};
         t2_ovf_q <= t2_top;
         div_q <= ~div_q;
         ext_m_q <= timer_ext_count_pin_i;
         ext_s_q <= ext_m_q;
         ext_p_q <= ext_s_q;
         rxd_m_q <= rxd_i;
         rxd_s_q <= rxd_m_q;
         rxd_p_q <= rxd_s_q;
      end
   end

   // ************************************************
   // transmitter and shift-register engine
   // ************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_st_q <= TX_IDLE;
         tsh_q <= 11'h7ff;
         tbit_q <= 4'h0;
         tos_q <= 4'h0;
         ph_q <= 3'h0;
         sdir_q <= 1'b0;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               tbit_q <= 4'h0;
               tos_q <= 4'h0;
               ph_q <= 3'h0;
               if (tx_go && mode == MODE_SHIFT) begin
                  tsh_q <= {3'h7, pwdata_i[7:0]};
                  sdir_q <= 1'b0;
                  tx_st_q <= TX_SYNC;
               end else if (tx_go) begin
                  tsh_q <= {1'b1, m9 ? ctl_q.tx_ninth_bit : 1'b1, pwdata_i[7:0], 1'b0};
                  tx_st_q <= TX_ASYNC;
               end else if (srx_go) begin
                  tsh_q <= 11'h7ff;
                  sdir_q <= 1'b1;
                  tx_st_q <= TX_SYNC;
               end
            end
            TX_ASYNC: begin
               if (tx_tk) begin
                  tos_q <= tos_q + 4'h1;
               end
               if (a_bit_end) begin
                  if (tbit_q == last) begin
                     tx_st_q <= TX_IDLE;
                  end else begin
                     tsh_q <= {1'b1, tsh_q[10:1]};
                     tbit_q <= tbit_q + 4'h1;
                  end
               end
            end
            TX_SYNC: begin
               ph_q <= s_bit_end ? 3'h0 : ph_q + 3'h1;
               if (s_smp && sdir_q) begin
                  tsh_q[7:0] <= {rxd_s_q, tsh_q[7:1]};
               end
               if (s_bit_end && !sdir_q) begin
                  tsh_q <= {1'b1, tsh_q[10:1]};
               end
               if (s_bit_end) begin
                  tbit_q <= tbit_q + 4'h1;
               end
               if (s_last || (sdir_q && !ctl_q.rx_enable)) begin
                  tx_st_q <= TX_IDLE;
               end
            end
            default: begin
               tx_st_q <= TX_IDLE;
            end
         endcase
      end
   end

   // ************************************************
   // asynchronous receiver
   // ************************************************
   // counter restarts on the start edge to align with bit cells
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_st_q <= RX_IDLE;
         ros_q <= 4'h0;
         rbit_q <= 4'h0;
         rsh_q <= 10'h000;
         vote_q <= 2'h3;
      end else begin
         case (rx_st_q)
            RX_IDLE: begin
               ros_q <= 4'h0;
               rbit_q <= 4'h0;
               if (rx_start) begin
                  rx_st_q <= RX_ASYNC;
               end
            end
            RX_ASYNC: begin
               if (rx_tk) begin
                  ros_q <= ros_q + 4'h1;
               end
               if (rx_tk && (ros_q == SMP_1 || ros_q == SMP_2)) begin
                  vote_q <= {vote_q[0], rxd_s_q};
               end
               if (rx_vote) begin
                  rbit_q <= rbit_q + 4'h1;
                  if (!rx_final) begin
                     rsh_q <= rx_frame;
                  end
               end
               if (rx_false || rx_final || !ctl_q.rx_enable) begin
                  rx_st_q <= RX_IDLE;
               end
            end
            default: begin
               rx_st_q <= RX_IDLE;
            end
         endcase
      end
   end

   // ************************************************
   // pin drivers
   // ************************************************
   // shift clock idles high, low for the first half of each bit
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         txd_q <= 1'b1;
         rxd_o_q <= 1'b1;
         rxd_oe_q <= 1'b0;
      end else begin
         txd_q <= (tx_st_q == TX_SYNC) ? (ph_q >= SYNC_PH_RISE) :
                  (tx_st_q == TX_ASYNC) ? tsh_q[0] : 1'b1;
         rxd_o_q <= (tx_st_q == TX_SYNC) ? tsh_q[0] : 1'b1;
         rxd_oe_q <= (tx_st_q == TX_SYNC) & ~sdir_q;
      end
   end

   assign prdata_o = rdat_q;
   assign pready_o = rdy_q;
   assign pslverr_o = err_q;
   assign txd_o = txd_q;
   assign rxd_o = rxd_o_q;
   assign rxd_oe_o = rxd_oe_q;

   // ************************************************
   // assertions
   // ************************************************
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   a_sync_clock_period: assert property (
      ($rose(txd_q) && tx_st_q == TX_SYNC && !sdir_q && tbit_q != SYNC_BITS)
      |-> ##6 $rose(txd_q)) else $error("shift clock period not six");
   a_sync_lsb_first: assert property (
      (tx_go && mode == MODE_SHIFT) |-> ##2 (rxd_oe_o && rxd_o == $past(pwdata_i[0], 2)))
      else $error("shift mode lsb not first");
   a_sync_tx_length: assert property (
      (tx_go && mode == MODE_SHIFT) |-> ##49 ctl_q.tx_done_flag)
      else $error("shift transfer not eight bits");
   a_txdone_cause: assert property (
      ($rose(ctl_q.tx_done_flag) && !$past(wr_ctl)) |-> $past(tx_evt))
      else $error("tx done set without frame end");
   a_rx_enable_gate: assert property (
      (rx_st_q == RX_IDLE && !ctl_q.rx_enable) |=> rx_st_q == RX_IDLE)
      else $error("reception started while disabled");
   a_mp_filter_drop: assert property (
      (rx_final && ctl_q.multiproc_filter_enable && !rx_ninth &&
       !ctl_q.rx_done_flag && !wr_ctl) |=> !ctl_q.rx_done_flag)
      else $error("filtered frame raised rx done");
   a_rx_load_fields: assert property (
      a_rx_load |=> (ctl_q.rx_done_flag && buf_q == $past(rx_byte) &&
                     ctl_q.rx_ninth_bit == $past(rx_ninth)))
      else $error("received frame not stored");
   a_rx_full_drop: assert property (
      (rx_final && ctl_q.rx_done_flag) |=> buf_q == $past(buf_q))
      else $error("frame overwrote full buffer");
   a_fe_sticky: assert property (
      (fe_q && !(wr_ctl && fes)) |=> fe_q)
      else $error("frame error cleared by hardware");
   a_fe_set: assert property (
      fe_evt |=> fe_q) else $error("bad stop bit not flagged");
   a_t2_reload: assert property (
      t2_top |=> (t2_q == $past(rld_q) && t2_ovf_q))
      else $error("timer did not reload");
   a_mode2_half_rate: assert property (
      (mode == MODE_UART9F && !dbl && m2_tk) |=> (!m2_tk || dbl))
      else $error("mode 2 tick too fast");
   a_ctl_bit7_view: assert property (
      (setup_done && !pwrite_i && hit_ctl) |=>
      prdata_o[7] == $past(fes ? fe_q : ctl_q.mode_select_upper))
      else $error("control bit 7 wrong role");
endmodule : fmsp_serial_port

// *** fmsp_remote_node.sv ***
/*
 Remote serial node beside the four-mode serial port: sends async frames,
 samples async frames, and acts as a shift register in shift mode.
 Assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/1ps
module fmsp_remote_node (
   // clock
   input wire logic sys_clk_i,
   // device pins
   input wire logic txd_i,
   input wire logic rxd_oe_i,
   input wire logic rxd_data_i,
   output logic rxd_o
);
   logic line_q = 1'b1;
   logic [7:0] sh_q = 8'h00;
   logic [10:0] got_q = '0;
   int sh_n = 0;
   time edge_t = 0;
   time per_t = 0;
   // idle line rests high, like a pulled-up wire
   assign rxd_o = line_q;
   // shift register: data is stable at each shift clock rise
   always @(posedge txd_i) begin
      if (rxd_oe_i) begin
         sh_q <= {rxd_data_i, sh_q[7:1]};
         sh_n <= sh_n + 1;
         per_t <= $time - edge_t;
         edge_t <= $time;
      end
   end
   // ********
   // async frames, lsb first, index 0 is the start bit
   // ********
   task automatic send(input logic [10:0] bits, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         line_q <= bits[i];
         repeat (per) @(posedge sys_clk_i);
      end
      line_q <= 1'b1;
   endtask : send
   // samples mid-bit, so a wrong bit rate shows as wrong bits
   task automatic recv(input int n, input int per);
      @(negedge txd_i);
      repeat (per / 2) @(posedge sys_clk_i);
      for (int i = 0; i < n; i++) begin
         got_q[i] = txd_i;
         repeat (per) @(posedge sys_clk_i);
      end
   endtask : recv
endmodule : fmsp_remote_node

// *** tb_top.sv ***
/*
 Directed testbench of the four-mode serial port over APB.
 Accepts any APB wait-state count and assumes timer 1 ticking every second clock.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module tb_top;
   import fmsp_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [ADDR_W-1:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0;
   logic timer1_ovf_i = 1'b0;
   logic ext_pin = 1'b1;
   logic [31:0] prdata_o, rd;
   logic pready_o, pslverr_o, rxd_o, rxd_oe_o, txd_o, node_rxd, err;
   wire line_w;
   int mismatches = 0;
   int n_tests = 0;
   // the device wins the shared receive wire while it drives it
   assign line_w = rxd_oe_o ? rxd_o : node_rxd;
   fmsp_serial_port uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .timer1_ovf_i(timer1_ovf_i), .timer_ext_count_pin_i(ext_pin), .rxd_i(line_w),
      .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
   fmsp_remote_node node (.sys_clk_i(sys_clk_i), .txd_i(txd_o), .rxd_oe_i(rxd_oe_o),
      .rxd_data_i(rxd_o), .rxd_o(node_rxd));
   always #5 sys_clk_i = ~sys_clk_i;
   // timer 1 tick every second clock: 32 clocks per bit
   always @(posedge sys_clk_i) timer1_ovf_i <= ~timer1_ovf_i;
   // timer 2 pin falls every second clock, counted only when selected
   always @(posedge sys_clk_i) ext_pin <= ~ext_pin;
   // ********
   // apb master
   // ********
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      // no wait-state count assumed: only the watchdog ends this wait
      do begin
         @(posedge sys_clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rdc
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   // watchdog: tests need about 72000 cycles
   initial begin
      repeat (90000) @(posedge sys_clk_i);
      mismatches++;
      end_of_test();
   end
   // ********
   // tests
   // ********
   initial begin
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rdc(OFS_CTRL, 32'h0);
      apb(1'b0, 12'h0fc, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      wr(OFS_RLD, 32'hfffc);
      wr(OFS_BAUD, 32'h1);
      $display("test registers done");
      wr(OFS_BUF, 32'ha5);
      repeat (60) @(posedge sys_clk_i);
      rdc(OFS_CTRL, 32'h02);
      `CHK({node.sh_n, node.sh_q}, {32'd8, 8'ha5})
      `CHK(node.per_t, 60)
      wr(OFS_CTRL, 32'h10);
      repeat (80) @(posedge sys_clk_i);
      rdc(OFS_CTRL, 32'h11);
      rdc(OFS_BUF, 32'hff);
      $display("test shift mode done");
      wr(OFS_CTRL, 32'h40);
      node.send({1'b1, 8'h5a, 1'b0}, 10, 32);
      rdc(OFS_CTRL, 32'h40);
      wr(OFS_CTRL, 32'h50);
      node.send({1'b1, 8'h5a, 1'b0}, 10, 32);
      rdc(OFS_CTRL, 32'h55);
      node.send({1'b1, 8'h11, 1'b0}, 10, 32);
      rdc(OFS_BUF, 32'h5a);
      $display("test uart8 receive done");
      wr(OFS_CTRL, 32'h70);
      wr(OFS_PWR, 32'h40);
      node.send({1'b0, 8'h77, 1'b0}, 10, 32);
      rdc(OFS_CTRL, 32'hf0);
      node.send({1'b1, 8'h21, 1'b0}, 10, 32);
      rdc(OFS_CTRL, 32'hf5);
      wr(OFS_PWR, 32'h0);
      rdc(OFS_CTRL, 32'h75);
      wr(OFS_PWR, 32'h40);
      wr(OFS_CTRL, 32'h70);
      rdc(OFS_CTRL, 32'h70);
      $display("test framing done");
      wr(OFS_PWR, 32'h80);
      wr(OFS_CTRL, 32'hb8);
      wr(OFS_BUF, 32'hc3);
      node.recv(11, 16);
      `CHK(node.got_q, {1'b1, 1'b1, 8'hc3, 1'b0})
      node.send({1'b1, 1'b0, 8'h44, 1'b0}, 11, 16);
      rdc(OFS_CTRL, 32'hba);
      node.send({1'b0, 1'b1, 8'h66, 1'b0}, 11, 16);
      rdc(OFS_CTRL, 32'hbf);
      rdc(OFS_BUF, 32'h66);
      wr(OFS_PWR, 32'h0);
      wr(OFS_BUF, 32'h2d);
      node.recv(11, 32);
      `CHK(node.got_q, {1'b1, 1'b1, 8'h2d, 1'b0})
      $display("test mode 2 done");
      // timer 2 may need one full roll before the reload rate applies
      repeat (66000) @(posedge sys_clk_i);
      wr(OFS_CTRL, 32'h40);
      wr(OFS_BUF, 32'h3c);
      node.recv(10, 64);
      `CHK(node.got_q[9:0], {1'b1, 8'h3c, 1'b0})
      rdc(OFS_CTRL, 32'h42);
      wr(OFS_CTRL, 32'hc0);
      wr(OFS_BUF, 32'h81);
      node.recv(11, 64);
      `CHK(node.got_q, {1'b1, 1'b0, 8'h81, 1'b0})
      // pin-clocked timer: four falling edges per overflow, 128 clocks per bit
      wr(OFS_BAUD, 32'h5);
      wr(OFS_BUF, 32'he7);
      node.recv(11, 128);
      `CHK(node.got_q, {1'b1, 1'b0, 8'he7, 1'b0})
      $display("test timer 2 done");
      end_of_test();
   end
endmodule : tb_top
